// File: verilog/aeqc_pkg.sv
`default_nettype none
package aeqc_pkg;

  // ***************************************
  // geometry
  // ***************************************
  localparam int NPORT = 4;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int WAIT_W = 23;

  // ***************************************
  // register offsets
  // ***************************************
  localparam logic [7:0] ADDR_PORT_DEBUG_FLAGS = 8'hD0;
  localparam logic [7:0] ADDR_EQ_ADAPT_CONTROL = 8'hD2;
  localparam logic [7:0] ADDR_EQ_ADAPT_STATE = 8'hD3;
  localparam logic [7:0] ADDR_EQ_MANUAL = 8'hD4;
  localparam logic [7:0] ADDR_EQ_LIMITS = 8'hD5;

  // ***************************************
  // field positions
  // ***************************************
  localparam int DBG_SELFTEST_BIT = 5;
  localparam logic [7:0] DBG_RW_MASK = 8'h5F;
  localparam int CTL_RELOCK_LSB = 5;
  localparam int CTL_FIRST_LOCK_BIT = 4;
  localparam int CTL_RESTART_BIT = 3;
  localparam int CTL_FLOOR_EN_BIT = 2;
  localparam int ST_STAGE1_LSB = 3;
  localparam int ST_STAGE2_LSB = 0;
  localparam int MAN_STAGE1_LSB = 5;
  localparam int MAN_LOCK_WAITS_BIT = 4;
  localparam int MAN_STAGE2_LSB = 1;
  localparam int MAN_OVERRIDE_BIT = 0;
  localparam int LIM_CEILING_LSB = 4;
  localparam int LIM_FLOOR_LSB = 0;

  // ***************************************
  // reset values
  // ***************************************
  localparam logic [2:0] RST_RELOCK_SEL = 3'h4;
  localparam logic [3:0] RST_FLOOR = 4'h8;
  localparam logic [3:0] RST_CEILING = 4'hF;
  localparam logic [2:0] RST_MAN_STAGE1 = 3'h3;
  localparam logic [2:0] RST_MAN_STAGE2 = 3'h0;

  // ***************************************
  // relock wait times and cycle counts
  // ***************************************
  localparam longint RELOCK_PS_0 = 164000000;
  localparam longint RELOCK_PS_1 = 328000000;
  localparam longint RELOCK_PS_2 = 655000000;
  localparam longint RELOCK_PS_3 = 1310000000;
  // the longer times exceed a 32-bit literal, so they are built in 64 bits
  localparam longint RELOCK_PS_4 = longint'(2620000) * 1000;
  localparam longint RELOCK_PS_5 = longint'(5240000) * 1000;
  localparam longint RELOCK_PS_6 = longint'(10500000) * 1000;
  localparam longint RELOCK_PS_7 = longint'(21000000) * 1000;
  localparam int RELOCK_CYC_0 = int'((RELOCK_PS_0 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int RELOCK_CYC_1 = int'((RELOCK_PS_1 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int RELOCK_CYC_2 = int'((RELOCK_PS_2 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int RELOCK_CYC_3 = int'((RELOCK_PS_3 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int RELOCK_CYC_4 = int'((RELOCK_PS_4 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int RELOCK_CYC_5 = int'((RELOCK_PS_5 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int RELOCK_CYC_6 = int'((RELOCK_PS_6 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int RELOCK_CYC_7 = int'((RELOCK_PS_7 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  // ***************************************
  // types
  // ***************************************
  typedef enum logic [1:0] {
    ST_START = 2'b00,
    ST_ADAPT = 2'b01,
    ST_LOCKED = 2'b10
  } aeqc_state_t;

  typedef struct packed {
    logic [2:0] relock_wait_select;
    logic first_lock_zero_start;
    logic floor_start_enable;
    logic [3:0] floor_setting;
    logic [3:0] setting_ceiling;
    logic manual_override;
    logic lock_waits_for_adapt;
    logic [2:0] manual_stage1_value;
    logic [2:0] manual_stage2_value;
  } aeqc_ctrl_t;

  localparam aeqc_ctrl_t RST_CTRL = '{
    relock_wait_select: RST_RELOCK_SEL,
    first_lock_zero_start: 1'b0,
    floor_start_enable: 1'b0,
    floor_setting: RST_FLOOR,
    setting_ceiling: RST_CEILING,
    manual_override: 1'b0,
    lock_waits_for_adapt: 1'b0,
    manual_stage1_value: RST_MAN_STAGE1,
    manual_stage2_value: RST_MAN_STAGE2
  };

  typedef struct packed {
    logic [2:0] stage1_state;
    logic [2:0] stage2_state;
  } aeqc_eq_t;

endpackage
`default_nettype wire

// File: verilog/aeqc_engine.sv
`timescale 1ns/10ps
`default_nettype none
module aeqc_engine (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire aeqc_pkg::aeqc_ctrl_t ctrl,
  input wire logic adapt_restart,
  input wire logic [aeqc_pkg::WAIT_W-1:0] wait_cycles,
  input wire logic lock_raw,
  output aeqc_pkg::aeqc_eq_t eq_state,
  output logic adapt_done,
  output logic lock_out
);
  import aeqc_pkg::*;

  aeqc_state_t state_q, state_d;
  logic [3:0] setting_q, setting_d;
  logic [WAIT_W-1:0] timer_q, timer_d;
  logic first_seen_q, first_seen_d;
  aeqc_eq_t eq_q, eq_d;
  logic [3:0] start_val;

  // setting index split over the two stages
  function automatic aeqc_eq_t map_setting(input logic [3:0] s);
    map_setting = '{stage1_state: {1'b0, s[3:2]}, stage2_state: {1'b0, s[1:0]}};
  endfunction

  always_comb begin
    start_val = ctrl.floor_start_enable ? ctrl.floor_setting : 4'h0;
    if (start_val > ctrl.setting_ceiling) begin
      start_val = ctrl.setting_ceiling;
    end
    state_d = state_q;
    setting_d = setting_q;
    timer_d = timer_q;
    first_seen_d = first_seen_q;
    if (ctrl.manual_override) begin
      state_d = ST_START;
      timer_d = '0;
    end else if (adapt_restart) begin
      setting_d = start_val;
      timer_d = '0;
      state_d = ST_ADAPT;
    end else begin
      case (state_q)
        ST_START: begin
          setting_d = start_val;
          timer_d = '0;
          state_d = ST_ADAPT;
        end
        ST_ADAPT: begin
          if (lock_raw) begin
            first_seen_d = 1'b1;
            timer_d = '0;
            if (ctrl.first_lock_zero_start && !first_seen_q) begin
              setting_d = 4'h0;
            end else begin
              state_d = ST_LOCKED;
            end
          end else if (timer_q >= wait_cycles - 1'b1) begin
            timer_d = '0;
            if (setting_q >= ctrl.setting_ceiling) begin
              setting_d = start_val;
            end else begin
              setting_d = setting_q + 4'h1;
            end
          end else begin
            timer_d = timer_q + 1'b1;
          end
        end
        ST_LOCKED: begin
          // losing lock resumes from the current setting rather than the start
          if (!lock_raw) begin
            state_d = ST_ADAPT;
            timer_d = '0;
          end
        end
        default: begin
          state_d = ST_START;
        end
      endcase
    end
    if (ctrl.manual_override) begin
      eq_d = '{stage1_state: ctrl.manual_stage1_value, stage2_state: ctrl.manual_stage2_value};
    end else begin
      eq_d = map_setting(setting_d);
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_q <= ST_START;
      setting_q <= 4'h0;
      timer_q <= '0;
      first_seen_q <= 1'b0;
      eq_q <= '0;
    end else begin
      state_q <= state_d;
      setting_q <= setting_d;
      timer_q <= timer_d;
      first_seen_q <= first_seen_d;
      eq_q <= eq_d;
    end
  end

  assign eq_state = eq_q;
  assign adapt_done = ctrl.manual_override | (state_q == ST_LOCKED);
  assign lock_out = lock_raw & (~ctrl.lock_waits_for_adapt | adapt_done);

endmodule
`default_nettype wire

// File: verilog/aeqc_top.sv
// Behaviour
// - step equalizer when lock wait expires
// - wait field selects 164us to 21ms
// - first-lock bit restarts adaptation at zero
// - restart bit restarts adaptation, self-clears
// - floor enable starts adaptation at floor
// - status shows two read-only stage fields
// - debug bit shows remote self-test active
// - floor value field, resets to eight
// - adaptation never exceeds ceiling setting
// - bypass uses manual stage select values
// - lock-mode makes lock wait for adaptation
`timescale 1ns/10ps
`default_nettype none
module aeqc_top #(
  parameter int RELOCK_CYC_0 = aeqc_pkg::RELOCK_CYC_0,
  parameter int RELOCK_CYC_1 = aeqc_pkg::RELOCK_CYC_1,
  parameter int RELOCK_CYC_2 = aeqc_pkg::RELOCK_CYC_2,
  parameter int RELOCK_CYC_3 = aeqc_pkg::RELOCK_CYC_3,
  parameter int RELOCK_CYC_4 = aeqc_pkg::RELOCK_CYC_4,
  parameter int RELOCK_CYC_5 = aeqc_pkg::RELOCK_CYC_5,
  parameter int RELOCK_CYC_6 = aeqc_pkg::RELOCK_CYC_6,
  parameter int RELOCK_CYC_7 = aeqc_pkg::RELOCK_CYC_7
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [1:0] reg_port_sel,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd_en,
  output logic [7:0] reg_rdata,
  input wire logic [aeqc_pkg::NPORT-1:0] rx_lock_raw,
  input wire logic [aeqc_pkg::NPORT-1:0] remote_selftest_active,
  output aeqc_pkg::aeqc_eq_t [aeqc_pkg::NPORT-1:0] eq_state,
  output logic [aeqc_pkg::NPORT-1:0] adapt_done,
  output logic [aeqc_pkg::NPORT-1:0] rx_lock
);
  import aeqc_pkg::*;

  // ***************************************
  // per-port register storage
  // ***************************************
  aeqc_ctrl_t ctrl_q [NPORT];
  aeqc_ctrl_t ctrl_d [NPORT];
  // debug bits 6 and 4:0 are plain storage with no function here
  logic [7:0] dbg_q [NPORT];
  logic [7:0] dbg_d [NPORT];
  logic [NPORT-1:0] restart_q, restart_d;
  logic [NPORT-1:0] selftest_q, selftest_d;
  logic [7:0] rdata_q, rdata_d;
  aeqc_eq_t [NPORT-1:0] eq_w;
  logic [WAIT_W-1:0] wait_q [NPORT];
  logic [WAIT_W-1:0] wait_d [NPORT];

  // register hit for the selected page
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // counts come from parameters so a short bench run can shrink them
  // wait field decode
  function automatic logic [WAIT_W-1:0] wait_count(input logic [2:0] sel);
    case (sel)
      3'h0: wait_count = WAIT_W'(RELOCK_CYC_0);
      3'h1: wait_count = WAIT_W'(RELOCK_CYC_1);
      3'h2: wait_count = WAIT_W'(RELOCK_CYC_2);
      3'h3: wait_count = WAIT_W'(RELOCK_CYC_3);
      3'h4: wait_count = WAIT_W'(RELOCK_CYC_4);
      3'h5: wait_count = WAIT_W'(RELOCK_CYC_5);
      3'h6: wait_count = WAIT_W'(RELOCK_CYC_6);
      default: wait_count = WAIT_W'(RELOCK_CYC_7);
    endcase
  endfunction

  // ***************************************
  // register writes
  // ***************************************
  always_comb begin
    restart_d = '0;
    // remote self-test level is sampled once so the read mux sees a settled bit
    selftest_d = remote_selftest_active;
    for (int p = 0; p < NPORT; p++) begin
      ctrl_d[p] = ctrl_q[p];
      dbg_d[p] = dbg_q[p];
      if (reg_wr_en && (reg_port_sel == 2'(p))) begin
        if (hit(reg_addr, ADDR_PORT_DEBUG_FLAGS)) begin
          dbg_d[p] = reg_wdata & DBG_RW_MASK;
        end else if (hit(reg_addr, ADDR_EQ_ADAPT_CONTROL)) begin
          ctrl_d[p].relock_wait_select = reg_wdata[CTL_RELOCK_LSB +: 3];
          ctrl_d[p].first_lock_zero_start = reg_wdata[CTL_FIRST_LOCK_BIT];
          ctrl_d[p].floor_start_enable = reg_wdata[CTL_FLOOR_EN_BIT];
          restart_d[p] = reg_wdata[CTL_RESTART_BIT];
        end else if (hit(reg_addr, ADDR_EQ_MANUAL)) begin
          ctrl_d[p].manual_stage1_value = reg_wdata[MAN_STAGE1_LSB +: 3];
          ctrl_d[p].lock_waits_for_adapt = reg_wdata[MAN_LOCK_WAITS_BIT];
          ctrl_d[p].manual_stage2_value = reg_wdata[MAN_STAGE2_LSB +: 3];
          ctrl_d[p].manual_override = reg_wdata[MAN_OVERRIDE_BIT];
        end else if (hit(reg_addr, ADDR_EQ_LIMITS)) begin
          ctrl_d[p].setting_ceiling = reg_wdata[LIM_CEILING_LSB +: 4];
          ctrl_d[p].floor_setting = reg_wdata[LIM_FLOOR_LSB +: 4];
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      for (int p = 0; p < NPORT; p++) begin
        ctrl_q[p] <= RST_CTRL;
        dbg_q[p] <= 8'h00;
      end
      restart_q <= '0;
      selftest_q <= '0;
    end else begin
      for (int p = 0; p < NPORT; p++) begin
        ctrl_q[p] <= ctrl_d[p];
        dbg_q[p] <= dbg_d[p];
      end
      restart_q <= restart_d;
      selftest_q <= selftest_d;
    end
  end

  // ***************************************
  // register reads
  // ***************************************
  // registered read data: a read and a write in one cycle return the old value
  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd_en) begin
      rdata_d = 8'h00;
      for (int p = 0; p < NPORT; p++) begin
        if (reg_port_sel == 2'(p)) begin
          if (hit(reg_addr, ADDR_PORT_DEBUG_FLAGS)) begin
            rdata_d = dbg_q[p];
            rdata_d[DBG_SELFTEST_BIT] = selftest_q[p];
          end else if (hit(reg_addr, ADDR_EQ_ADAPT_CONTROL)) begin
            // restart always reads back zero since it is a pulse
            rdata_d[CTL_RELOCK_LSB +: 3] = ctrl_q[p].relock_wait_select;
            rdata_d[CTL_FIRST_LOCK_BIT] = ctrl_q[p].first_lock_zero_start;
            rdata_d[CTL_FLOOR_EN_BIT] = ctrl_q[p].floor_start_enable;
          end else if (hit(reg_addr, ADDR_EQ_ADAPT_STATE)) begin
            rdata_d[ST_STAGE1_LSB +: 3] = eq_w[p].stage1_state;
            rdata_d[ST_STAGE2_LSB +: 3] = eq_w[p].stage2_state;
          end else if (hit(reg_addr, ADDR_EQ_MANUAL)) begin
            rdata_d[MAN_STAGE1_LSB +: 3] = ctrl_q[p].manual_stage1_value;
            rdata_d[MAN_LOCK_WAITS_BIT] = ctrl_q[p].lock_waits_for_adapt;
            rdata_d[MAN_STAGE2_LSB +: 3] = ctrl_q[p].manual_stage2_value;
            rdata_d[MAN_OVERRIDE_BIT] = ctrl_q[p].manual_override;
          end else if (hit(reg_addr, ADDR_EQ_LIMITS)) begin
            rdata_d[LIM_CEILING_LSB +: 4] = ctrl_q[p].setting_ceiling;
            rdata_d[LIM_FLOOR_LSB +: 4] = ctrl_q[p].floor_setting;
          end
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // ***************************************
  // relock wait decode
  // ***************************************
  // registered so the eight-way constant mux stays out of the timer compare path
  // a new wait choice therefore reaches the timer one cycle after the write
  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      wait_d[p] = wait_count(ctrl_q[p].relock_wait_select);
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      for (int p = 0; p < NPORT; p++) begin
        wait_q[p] <= wait_count(RST_RELOCK_SEL);
      end
    end else begin
      for (int p = 0; p < NPORT; p++) begin
        wait_q[p] <= wait_d[p];
      end
    end
  end

  // ***************************************
  // per-port adaptation engines
  // ***************************************
  // one engine per port keeps ports fully independent at the cost of four timers
  for (genvar g = 0; g < NPORT; g++) begin : g_port
    aeqc_engine u_engine (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .ctrl(ctrl_q[g]),
      .adapt_restart(restart_q[g]),
      .wait_cycles(wait_q[g]),
      .lock_raw(rx_lock_raw[g]),
      .eq_state(eq_w[g]),
      .adapt_done(adapt_done[g]),
      .lock_out(rx_lock[g])
    );
  end

  assign eq_state = eq_w;

endmodule
`default_nettype wire

// File: sim/aeqc_props.sv
`timescale 1ns/10ps
`default_nettype none
module aeqc_props (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [1:0] reg_port_sel,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_rdata,
  input wire logic [aeqc_pkg::NPORT-1:0] rx_lock_raw,
  input wire logic [aeqc_pkg::NPORT-1:0] remote_selftest_active,
  input wire aeqc_pkg::aeqc_eq_t [aeqc_pkg::NPORT-1:0] eq_state,
  input wire logic [aeqc_pkg::NPORT-1:0] adapt_done,
  input wire logic [aeqc_pkg::NPORT-1:0] rx_lock
);
  import aeqc_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // ***************************************
  // shadow of port 0 writes
  // ***************************************
  logic [7:0] man_q, man_d, lim_q, lim_d;
  logic [NPORT-1:0] act_q;
  logic [3:0] set0, start_exp;
  logic [5:0] st_sel;
  logic dbg_sel;
  always_comb begin
    man_d = man_q;
    lim_d = lim_q;
    if (reg_wr_en && reg_port_sel == 2'h0 && reg_addr == ADDR_EQ_MANUAL) begin
      man_d = reg_wdata;
    end
    if (reg_wr_en && reg_port_sel == 2'h0 && reg_addr == ADDR_EQ_LIMITS) begin
      lim_d = reg_wdata;
    end
    if (sys_rst) begin
      man_d = 8'h60;
      lim_d = 8'hF8;
    end
  end
  always_ff @(posedge mclk) begin
    man_q <= man_d;
    lim_q <= lim_d;
    act_q <= remote_selftest_active;
  end
  assign set0 = {eq_state[0].stage1_state[1:0], eq_state[0].stage2_state[1:0]};
  // floor above the ceiling is clamped, so the start never overshoots
  assign start_exp = (lim_q[3:0] > lim_q[7:4]) ? lim_q[7:4] : lim_q[3:0];
  assign st_sel = eq_state[reg_port_sel];
  assign dbg_sel = act_q[reg_port_sel];
  reset_clear_a: assert property (disable iff (1'b0) sys_rst |=> eq_state == '0 && reg_rdata == 8'h00)
    else $error("state not cleared by reset");
  status_read_a: assert property (reg_rd_en && reg_addr == ADDR_EQ_ADAPT_STATE
    |=> reg_rdata == {2'b00, $past(st_sel)})
    else $error("status read differs from equalizer state");
  selftest_read_a: assert property (reg_rd_en && reg_addr == ADDR_PORT_DEBUG_FLAGS
    |=> !reg_rdata[7] && reg_rdata[5] == $past(dbg_sel))
    else $error("self-test flag read wrong");
  restart_clear_a: assert property (reg_rd_en && reg_addr == ADDR_EQ_ADAPT_CONTROL
    |=> reg_rdata[3] == 1'b0 && reg_rdata[1:0] == 2'b00)
    else $error("restart or reserved bits read nonzero");
  lock_gate_a: assert property ((rx_lock & ~rx_lock_raw) == '0
    && (rx_lock_raw & adapt_done & ~rx_lock) == '0
    && (!man_q[4] || adapt_done[0] || !rx_lock[0]) && (man_q[4] || rx_lock[0] == rx_lock_raw[0]))
    else $error("reported lock disagrees with raw lock");
  locked_hold_a: assert property (adapt_done[0] && rx_lock_raw[0] && !reg_wr_en && !$past(reg_wr_en)
    |=> $stable(eq_state[0]))
    else $error("setting moved while locked");
  // manual values
  // a write in the sampled cycle changes the bypass next edge, so it is left out
  bypass_value_a: assert property (man_q[0] && $stable(man_q) && man_d == man_q
    |=> eq_state[0] == {man_q[7:5], man_q[3:1]} && adapt_done[0])
    else $error("bypass does not apply manual values");
  start_value_a: assert property (reg_wr_en && reg_port_sel == 2'h0 && reg_addr == ADDR_EQ_ADAPT_CONTROL
    && reg_wdata[3] && !man_q[0] |-> ##2 set0 == ($past(reg_wdata[2], 2) ? start_exp : 4'h0))
    else $error("restart did not begin at start value");
endmodule
bind aeqc_top aeqc_props u_props (.mclk(mclk), .sys_rst(sys_rst), .reg_port_sel(reg_port_sel), .reg_addr(reg_addr),
  .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
  .rx_lock_raw(rx_lock_raw), .remote_selftest_active(remote_selftest_active), .eq_state(eq_state),
  .adapt_done(adapt_done), .rx_lock(rx_lock));
`default_nettype wire

// File: sim/aeqc_remote_model.sv
`timescale 1ns/10ps
`default_nettype none
module aeqc_remote_model (
  input wire aeqc_pkg::aeqc_eq_t [aeqc_pkg::NPORT-1:0] eq_state,
  input wire logic [aeqc_pkg::NPORT-1:0] link_up,
  input wire logic [3:0] good_setting,
  input wire logic [aeqc_pkg::NPORT-1:0] selftest_on,
  output logic [aeqc_pkg::NPORT-1:0] rx_lock_raw,
  output logic [aeqc_pkg::NPORT-1:0] remote_selftest_active
);
  import aeqc_pkg::*;
  // lock only at the matching setting, lost at once when it moves away
  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      rx_lock_raw[p] = link_up[p] && {eq_state[p].stage1_state[1:0], eq_state[p].stage2_state[1:0]} == good_setting;
    end
  end
  assign remote_selftest_active = selftest_on;
endmodule
`default_nettype wire

// File: sim/aeqc_tb.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import aeqc_pkg::*;
  localparam int W[8] = '{4, 6, 8, 10, 12, 14, 16, 18};
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [1:0] sel = 2'h0;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic [NPORT-1:0] raw, st_act, done, lock;
  logic [NPORT-1:0] link = '0;
  logic [NPORT-1:0] st_on = '0;
  logic [3:0] good = 4'h5;
  aeqc_eq_t [NPORT-1:0] eq;
  int errors = 0;
  int cmp_count = 0;
  always #2.5 mclk = ~mclk;
  aeqc_top #(.RELOCK_CYC_0(W[0]), .RELOCK_CYC_1(W[1]), .RELOCK_CYC_2(W[2]), .RELOCK_CYC_3(W[3]),
    .RELOCK_CYC_4(W[4]), .RELOCK_CYC_5(W[5]), .RELOCK_CYC_6(W[6]), .RELOCK_CYC_7(W[7])) dut (.mclk(mclk),
    .sys_rst(sys_rst), .reg_port_sel(sel), .reg_addr(addr), .reg_wr_en(wr), .reg_wdata(wdata), .reg_rd_en(rd),
    .reg_rdata(rdata), .rx_lock_raw(raw), .remote_selftest_active(st_act), .eq_state(eq), .adapt_done(done),
    .rx_lock(lock));
  aeqc_remote_model remote (.eq_state(eq), .link_up(link), .good_setting(good), .selftest_on(st_on),
    .rx_lock_raw(raw), .remote_selftest_active(st_act));
  // ***************************************
  // helpers
  // ***************************************
  task automatic end_of_test();
    if (errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [1:0] p, input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    sel = p;
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge mclk);
    wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [1:0] p, input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk);
    sel = p;
    addr = a;
    rd = 1'b1;
    @(negedge mclk);
    rd = 1'b0;
    chk(rdata, exp);
  endtask
  function automatic logic [3:0] setting(input int p);
    return {eq[p].stage1_state[1:0], eq[p].stage2_state[1:0]};
  endfunction
  // bounded wait on a setting; the caller judges the count
  task automatic wait_set(input int p, input logic [3:0] s, output int n);
    n = 0;
    while (setting(p) !== s && n < 200) begin
      @(negedge mclk);
      n++;
    end
  endtask
  // ***************************************
  // scenarios
  // ***************************************
  task automatic t_reset();
    rd_chk(0, ADDR_EQ_ADAPT_STATE, 8'h00);
    for (int p = 0; p < NPORT; p++) begin
      rd_chk(p[1:0], ADDR_PORT_DEBUG_FLAGS, 8'h00);
      rd_chk(p[1:0], ADDR_EQ_ADAPT_CONTROL, 8'h80);
      rd_chk(p[1:0], ADDR_EQ_MANUAL, 8'h60);
      rd_chk(p[1:0], ADDR_EQ_LIMITS, 8'hF8);
    end
    wr_reg(0, ADDR_EQ_ADAPT_CONTROL, 8'h88);
    rd_chk(0, ADDR_EQ_ADAPT_CONTROL, 8'h80);
  endtask
  task automatic t_wait();
    int n;
    for (int k = 0; k < 8; k++) begin
      wr_reg(0, ADDR_EQ_ADAPT_CONTROL, {k[2:0], 5'h08});
      // let the restart land so an old setting of one is not taken as the new one
      repeat (2) @(negedge mclk);
      wait_set(0, 4'h1, n);
      wait_set(0, 4'h2, n);
      chk(8'(n), 8'(W[k]));
    end
  endtask
  task automatic t_floor();
    int n;
    wr_reg(0, ADDR_EQ_LIMITS, 8'h63);
    wr_reg(0, ADDR_EQ_ADAPT_CONTROL, 8'h0C);
    repeat (3) @(negedge mclk);
    chk(8'(setting(0)), 8'h03);
    wait_set(0, 4'h6, n);
    wait_set(0, 4'h3, n);
    chk(8'(n), 8'(W[0]));
    wr_reg(0, ADDR_EQ_LIMITS, 8'hF8);
  endtask
  task automatic t_first_lock();
    int n;
    wr_reg(0, ADDR_EQ_ADAPT_CONTROL, 8'h18);
    link[0] = 1'b1;
    wait_set(0, 4'h5, n);
    @(negedge mclk);
    wait_set(0, 4'h0, n);
    chk(8'(setting(0)), 8'h00);
    n = 0;
    while (done[0] !== 1'b1 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    chk(8'(setting(0)), 8'h05);
    chk(8'(lock[0]), 8'h01);
    wr_reg(0, ADDR_EQ_MANUAL, 8'h70);
    wr_reg(0, ADDR_EQ_ADAPT_CONTROL, 8'h08);
    repeat (40) begin
      @(negedge mclk);
      chk(8'(lock[0]), 8'(raw[0] & done[0]));
    end
    link[0] = 1'b0;
  endtask
  task automatic t_bypass();
    wr_reg(0, ADDR_EQ_MANUAL, 8'hA5);
    repeat (2) @(negedge mclk);
    chk({2'b00, eq[0]}, 8'h2A);
    chk(8'(done[0]), 8'h01);
    rd_chk(0, ADDR_EQ_ADAPT_STATE, 8'h2A);
    wr_reg(0, ADDR_EQ_MANUAL, 8'h60);
    repeat (2) @(negedge mclk);
    chk(8'(done[0]), 8'h00);
  endtask
  task automatic t_ports();
    st_on = 4'b0010;
    wr_reg(2, ADDR_EQ_LIMITS, 8'h73);
    rd_chk(2, ADDR_EQ_LIMITS, 8'h73);
    rd_chk(1, ADDR_EQ_LIMITS, 8'hF8);
    rd_chk(1, ADDR_PORT_DEBUG_FLAGS, 8'h20);
    wr_reg(0, ADDR_PORT_DEBUG_FLAGS, 8'hFF);
    rd_chk(0, ADDR_PORT_DEBUG_FLAGS, 8'h5F);
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    @(negedge mclk);
    sys_rst = 1'b0;
    t_reset();
    t_wait();
    t_floor();
    t_first_lock();
    t_bypass();
    t_ports();
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    end_of_test();
  end
endmodule
`default_nettype wire
